// File: core/fch_pkg.sv
package fch_pkg;
   // Command codes
   localparam logic [7:0] OP_ARM = 8'h32;
   localparam logic [7:0] OP_PROG = 8'h33;
   localparam logic [7:0] OP_ERASE = 8'h34;
   localparam logic [7:0] OP_BLANK = 8'h35;
   localparam logic [7:0] OP_ID = 8'h36;
   localparam logic [7:0] OP_VER = 8'h37;
   localparam logic [7:0] OP_CMP = 8'h38;
   localparam logic [7:0] OP_LOADER = 8'h39;

   typedef enum logic [3:0] {
      status_ok = 4'h0,
      status_unknown_op = 4'h1,
      status_src_misaligned = 4'h2,
      status_dst_misaligned = 4'h3,
      status_src_unmapped = 4'h4,
      status_dst_unmapped = 4'h5,
      status_bad_length = 4'h6,
      status_bad_sector = 4'h7,
      status_not_erased = 4'h8,
      status_not_armed = 4'h9,
      status_mismatch = 4'hA,
      status_busy = 4'hB
   } fch_status_e;

   typedef enum logic [2:0] {
      st_idle = 3'h1,
      st_read = 3'h2,
      st_done = 3'h4
   } fch_state_e;

   // Program lengths, alignments and word values
   localparam logic [31:0] LEN_256 = 32'h0000_0100;
   localparam logic [31:0] LEN_512 = 32'h0000_0200;
   localparam logic [31:0] LEN_1K = 32'h0000_0400;
   localparam logic [31:0] LEN_4K = 32'h0000_1000;
   localparam logic [31:0] DST_ALIGN_MASK = 32'h0000_00FF;
   localparam logic [31:0] WORD_MASK = 32'h0000_0003;
   localparam logic [31:0] WORD_BYTES = 32'h0000_0004;
   localparam logic [31:0] ERASED_WORD = 32'hFFFF_FFFF;
   localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
   // Low area that may be remapped; compares over it are unreliable
   localparam logic [31:0] REMAP_BYTES = 32'h0000_0040;
   localparam logic [1:0] PBUS_DIV_LOADER = 2'h0;

   localparam int RES_W = 68;
endpackage

// File: core/fch_region.sv
`timescale 1ns/1ps
module fch_region #(
   parameter logic [32:0] FLASH_BYTES = 33'h0_0001_0000,
   parameter logic [32:0] RAM_BASE = 33'h0_4000_0000,
   parameter logic [32:0] RAM_BYTES = 33'h0_0000_8000,
   parameter int SEC_SHIFT = 12,
   parameter int SEC_W = 4
) (
   // Region
   input wire logic [31:0] addr,
   input wire logic [31:0] len,
   // Checks
   output logic mapped,
   output logic in_flash,
   output logic [SEC_W-1:0] sec_first,
   output logic [SEC_W-1:0] sec_last
);
   logic [32:0] last;
   logic in_ram;

   // Whole span is checked, not only the start
   assign last = (len == 32'h0) ? {1'b0, addr}
      : {1'b0, addr} + {1'b0, len} - 33'h1;
   assign in_flash = last < FLASH_BYTES;
   assign in_ram = ({1'b0, addr} >= RAM_BASE)
      && (last < RAM_BASE + RAM_BYTES);
   assign mapped = in_flash || in_ram;
   assign sec_first = addr[SEC_SHIFT +: SEC_W];
   assign sec_last = last[SEC_SHIFT +: SEC_W];
endmodule

// File: core/fch_buf2.sv
`timescale 1ns/1ps
module fch_buf2 #(
   parameter int W = 8,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [PW-1:0] wp;
      logic [PW-1:0] rp;
      logic [PW:0] cnt;
   } fch_buf_s;

   fch_buf_s s;
   fch_buf_s next_s;
   logic push;
   logic pop;

   assign in_ready = s.cnt != (PW+1)'(DEPTH);
   assign out_valid = s.cnt != '0;
   assign out_data = s.mem[s.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_s = s;
      if (push) begin
         next_s.mem[s.wp] = in_data;
         next_s.wp = (s.wp == PW'(DEPTH-1)) ? '0 : s.wp + PW'(1);
      end
      if (pop) begin
         next_s.rp = (s.rp == PW'(DEPTH-1)) ? '0 : s.rp + PW'(1);
      end
      next_s.cnt = s.cnt + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end
endmodule

// File: core/fch_core.sv
// Function
// - Program code 51 needs a 256-byte aligned destination, else dst error.
// - Program source must be word aligned, else source error.
// - Program length only 256, 512, 1024 or 4096, else length error.
// - Program needs armed sectors; success disarms them again.
// - Boot sector is never programmed.
// - Erase code 52 over start..end sectors; boot never erased.
// - Erase answers ok, busy, not armed or bad sector; needs arming.
// - Blank check code 53 gives offset and contents of first used word.
// - Identification code 54 returns ok and the part word.
// - Version code 55 returns major in byte 1, minor in byte 0.
// - Compare code 56 checks length, alignment and mapping.
// - Compare mismatch returns offset of first differing word.
// - Compare over the lowest 64 bytes may be wrong.
// - Loader code 57: no status, maps vectors, pin input, divider 0.
// - Loader entry leaves the clock multiplier running.
// - Status codes 0 to 11 in the fixed order.
// - Busy status 11 while flash hardware is occupied.
// - Unmapped checks cover address plus byte count.
// - Arm code 50 over sector range; boot cannot be armed.
// - Unknown codes return unknown status and do nothing.
// - Flash array unreadable during write or erase.
`timescale 1ns/1ps
module fch_core #(
   parameter int NSEC = 16,
   parameter int SEC_SHIFT = 12,
   parameter logic [31:0] RAM_BASE = 32'h4000_0000,
   parameter logic [31:0] RAM_BYTES = 32'h0000_8000,
   // Arbitrary identification value
   parameter logic [31:0] PART_ID = 32'h0000_1234,
   parameter logic [7:0] VER_MAJOR = 8'h31,
   parameter logic [7:0] VER_MINOR = 8'h30
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Command table
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_code,
   input wire logic [31:0] cmd_param0,
   input wire logic [31:0] cmd_param1,
   input wire logic [31:0] cmd_param2,
   input wire logic [31:0] cmd_param3,
   // Result table
   output logic res_valid,
   input wire logic res_ready,
   output logic [3:0] res_status,
   output logic [31:0] res_word0,
   output logic [31:0] res_word1,
   // Memory read port
   output logic mem_rd_req,
   output logic [31:0] mem_rd_addr,
   input wire logic mem_rd_ack,
   input wire logic [31:0] mem_rd_data,
   // Flash engine
   output logic flash_start,
   output logic flash_erase,
   output logic [31:0] flash_a,
   output logic [31:0] flash_b,
   output logic [31:0] flash_len,
   output logic [31:0] core_clock_khz,
   input wire logic flash_hw_busy,
   output logic array_read_block,
   // Loader entry
   output logic loader_enter,
   output logic boot_vec_map,
   input wire logic app_rx_oe,
   output logic loader_rx_pin_oe,
   input wire logic [1:0] app_pbus_div,
   output logic [1:0] peripheral_bus_divider
);
   localparam int SW = $clog2(NSEC);
   localparam logic [SW-1:0] BOOT_SEC = SW'(NSEC-1);
   localparam logic [32:0] FLASH_BYTES = 33'(NSEC) << SEC_SHIFT;

   typedef struct packed {
      fch_pkg::fch_state_e st;
      logic [7:0] code;
      fch_pkg::fch_status_e status;
      logic [31:0] r0;
      logic [31:0] r1;
      logic [31:0] a;
      logic [31:0] b;
      logic [31:0] left;
      logic [31:0] off;
      logic [31:0] word_a;
      logic phase;
      logic [NSEC-1:0] armed;
      logic fl_start;
      logic fl_erase;
      logic [31:0] fl_a;
      logic [31:0] fl_b;
      logic [31:0] fl_len;
      logic [31:0] fl_khz;
      logic loader_mode;
      logic loader_enter;
   } fch_core_s;

   localparam fch_core_s RST = '{st: fch_pkg::st_idle,
      status: fch_pkg::status_ok, default: '0};

   fch_core_s s;
   fch_core_s next_s;
   logic accept;
   logic busy;
   logic buf_ready;
   logic sec_ok;
   logic [NSEC-1:0] rng_mask;
   logic [NSEC-1:0] prog_mask;
   logic len_ok;
   logic d_map;
   logic d_flash;
   logic s_map;
   logic [SW-1:0] d_first;
   logic [SW-1:0] d_last;
   logic [31:0] rd_addr;

   function automatic logic [NSEC-1:0] sec_mask(input logic [SW-1:0] lo,
         input logic [SW-1:0] hi);
      logic [NSEC-1:0] m;
      m = '0;
      for (int i = 0; i < NSEC; i++) begin
         m[i] = (SW'(i) >= lo) && (SW'(i) <= hi);
      end
      return m;
   endfunction

   fch_region #(.FLASH_BYTES(FLASH_BYTES), .RAM_BASE({1'b0, RAM_BASE}),
      .RAM_BYTES({1'b0, RAM_BYTES}), .SEC_SHIFT(SEC_SHIFT), .SEC_W(SW))
   u_dst (
      .addr(cmd_param0),
      .len(cmd_param2),
      .mapped(d_map),
      .in_flash(d_flash),
      .sec_first(d_first),
      .sec_last(d_last)
   );

   fch_region #(.FLASH_BYTES(FLASH_BYTES), .RAM_BASE({1'b0, RAM_BASE}),
      .RAM_BYTES({1'b0, RAM_BYTES}), .SEC_SHIFT(SEC_SHIFT), .SEC_W(SW))
   u_src (
      .addr(cmd_param1),
      .len(cmd_param2),
      .mapped(s_map),
      .in_flash(),
      .sec_first(),
      .sec_last()
   );

   // Results queue; a stalled caller loses no answer
   fch_buf2 #(.W(fch_pkg::RES_W), .DEPTH(2)) u_res (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .in_valid(s.st == fch_pkg::st_done),
      .in_ready(buf_ready),
      .in_data({s.status, s.r0, s.r1}),
      .out_valid(res_valid),
      .out_ready(res_ready),
      .out_data({res_status, res_word0, res_word1})
   );

   assign busy = flash_hw_busy || s.fl_start;
   assign cmd_ready = s.st == fch_pkg::st_idle;
   assign accept = cmd_valid && cmd_ready;
   assign sec_ok = (cmd_param0 <= cmd_param1)
      && (cmd_param1 < 32'(NSEC));
   assign rng_mask = sec_mask(cmd_param0[SW-1:0], cmd_param1[SW-1:0]);
   assign prog_mask = sec_mask(d_first, d_last);
   assign len_ok = cmd_param2 == fch_pkg::LEN_256
      || cmd_param2 == fch_pkg::LEN_512
      || cmd_param2 == fch_pkg::LEN_1K
      || cmd_param2 == fch_pkg::LEN_4K;
   assign array_read_block = busy;
   assign rd_addr = s.phase ? s.b : s.a;
   assign mem_rd_addr = rd_addr;
   // Flash words wait while the array is being written
   assign mem_rd_req = (s.st == fch_pkg::st_read)
      && !(busy && {1'b0, rd_addr} < FLASH_BYTES);
   assign flash_start = s.fl_start;
   assign flash_erase = s.fl_erase;
   assign flash_a = s.fl_a;
   assign flash_b = s.fl_b;
   assign flash_len = s.fl_len;
   assign core_clock_khz = s.fl_khz;
   assign loader_enter = s.loader_enter;
   assign boot_vec_map = s.loader_mode;
   assign loader_rx_pin_oe = app_rx_oe && !s.loader_mode;
   assign peripheral_bus_divider = s.loader_mode
      ? fch_pkg::PBUS_DIV_LOADER : app_pbus_div;

   always_comb begin
      next_s = s;
      next_s.fl_start = 1'b0;
      next_s.loader_enter = 1'b0;
      case (s.st)
         fch_pkg::st_idle: begin
            if (accept) begin
               next_s.code = cmd_code;
               next_s.r0 = fch_pkg::ZERO_WORD;
               next_s.r1 = fch_pkg::ZERO_WORD;
               next_s.status = fch_pkg::status_ok;
               next_s.st = fch_pkg::st_done;
               next_s.phase = 1'b0;
               next_s.off = fch_pkg::ZERO_WORD;
               case (cmd_code)
                  fch_pkg::OP_ARM: begin
                     if (busy) begin
                        next_s.status = fch_pkg::status_busy;
                     end else if (!sec_ok || rng_mask[BOOT_SEC]) begin
                        next_s.status = fch_pkg::status_bad_sector;
                     end else begin
                        next_s.armed = s.armed | rng_mask;
                     end
                  end
                  fch_pkg::OP_PROG: begin
                     if (busy) begin
                        next_s.status = fch_pkg::status_busy;
                     end else if ((cmd_param0 & fch_pkg::DST_ALIGN_MASK)
                           != fch_pkg::ZERO_WORD) begin
                        next_s.status = fch_pkg::status_dst_misaligned;
                     end else if ((cmd_param1 & fch_pkg::WORD_MASK)
                           != fch_pkg::ZERO_WORD) begin
                        next_s.status = fch_pkg::status_src_misaligned;
                     end else if (!len_ok) begin
                        next_s.status = fch_pkg::status_bad_length;
                     end else if (!s_map) begin
                        next_s.status = fch_pkg::status_src_unmapped;
                     end else if (!d_flash) begin
                        next_s.status = fch_pkg::status_dst_unmapped;
                     end else if (prog_mask[BOOT_SEC]) begin
                        next_s.status = fch_pkg::status_not_armed;
                     end else if ((s.armed & prog_mask) != prog_mask) begin
                        next_s.status = fch_pkg::status_not_armed;
                     end else begin
                        // Each call stands alone; hosts step the target
                        next_s.fl_start = 1'b1;
                        next_s.fl_erase = 1'b0;
                        next_s.fl_a = cmd_param0;
                        next_s.fl_b = cmd_param1;
                        next_s.fl_len = cmd_param2;
                        next_s.fl_khz = cmd_param3;
                        next_s.armed = s.armed & ~prog_mask;
                     end
                  end
                  fch_pkg::OP_ERASE: begin
                     if (busy) begin
                        next_s.status = fch_pkg::status_busy;
                     end else if (!sec_ok || rng_mask[BOOT_SEC]) begin
                        next_s.status = fch_pkg::status_bad_sector;
                     end else if ((s.armed & rng_mask) != rng_mask) begin
                        next_s.status = fch_pkg::status_not_armed;
                     end else begin
                        next_s.fl_start = 1'b1;
                        next_s.fl_erase = 1'b1;
                        next_s.fl_a = cmd_param0;
                        next_s.fl_b = cmd_param1;
                        next_s.fl_len = fch_pkg::ZERO_WORD;
                        next_s.fl_khz = cmd_param2;
                        next_s.armed = s.armed & ~rng_mask;
                     end
                  end
                  fch_pkg::OP_BLANK: begin
                     if (busy) begin
                        next_s.status = fch_pkg::status_busy;
                     end else if (!sec_ok) begin
                        next_s.status = fch_pkg::status_bad_sector;
                     end else begin
                        next_s.st = fch_pkg::st_read;
                        next_s.a = cmd_param0 << SEC_SHIFT;
                        next_s.left = (cmd_param1 - cmd_param0
                           + 32'h1) << SEC_SHIFT;
                     end
                  end
                  fch_pkg::OP_ID: begin
                     next_s.r0 = PART_ID;
                  end
                  fch_pkg::OP_VER: begin
                     next_s.r0 = {16'h0, VER_MAJOR, VER_MINOR};
                  end
                  fch_pkg::OP_CMP: begin
                     // Low remappable bytes are compared as read
                     if ((cmd_param2 & fch_pkg::WORD_MASK)
                           != fch_pkg::ZERO_WORD) begin
                        next_s.status = fch_pkg::status_bad_length;
                     end else if ((cmd_param0 & fch_pkg::WORD_MASK)
                           != fch_pkg::ZERO_WORD) begin
                        next_s.status = fch_pkg::status_dst_misaligned;
                     end else if ((cmd_param1 & fch_pkg::WORD_MASK)
                           != fch_pkg::ZERO_WORD) begin
                        next_s.status = fch_pkg::status_src_misaligned;
                     end else if (!d_map) begin
                        next_s.status = fch_pkg::status_dst_unmapped;
                     end else if (!s_map) begin
                        next_s.status = fch_pkg::status_src_unmapped;
                     end else if (cmd_param2 != fch_pkg::ZERO_WORD) begin
                        next_s.st = fch_pkg::st_read;
                        next_s.a = cmd_param0;
                        next_s.b = cmd_param1;
                        next_s.left = cmd_param2;
                     end
                  end
                  fch_pkg::OP_LOADER: begin
                     // No answer; clock multiplier is left untouched
                     next_s.st = fch_pkg::st_idle;
                     next_s.loader_mode = 1'b1;
                     next_s.loader_enter = 1'b1;
                  end
                  default: begin
                     next_s.status = fch_pkg::status_unknown_op;
                  end
               endcase
            end
         end
         fch_pkg::st_read: begin
            if (mem_rd_req && mem_rd_ack) begin
               if (s.code == fch_pkg::OP_BLANK) begin
                  if (mem_rd_data != fch_pkg::ERASED_WORD) begin
                     next_s.status = fch_pkg::status_not_erased;
                     next_s.r0 = s.off;
                     next_s.r1 = mem_rd_data;
                     next_s.st = fch_pkg::st_done;
                  end else begin
                     next_s.a = s.a + fch_pkg::WORD_BYTES;
                     next_s.off = s.off + fch_pkg::WORD_BYTES;
                     next_s.left = s.left - fch_pkg::WORD_BYTES;
                     if (s.left == fch_pkg::WORD_BYTES) begin
                        next_s.st = fch_pkg::st_done;
                     end
                  end
               end else if (!s.phase) begin
                  next_s.word_a = mem_rd_data;
                  next_s.phase = 1'b1;
               end else begin
                  next_s.phase = 1'b0;
                  if (mem_rd_data != s.word_a) begin
                     next_s.status = fch_pkg::status_mismatch;
                     next_s.r0 = s.off;
                     next_s.st = fch_pkg::st_done;
                  end else begin
                     next_s.a = s.a + fch_pkg::WORD_BYTES;
                     next_s.b = s.b + fch_pkg::WORD_BYTES;
                     next_s.off = s.off + fch_pkg::WORD_BYTES;
                     next_s.left = s.left - fch_pkg::WORD_BYTES;
                     if (s.left == fch_pkg::WORD_BYTES) begin
                        next_s.st = fch_pkg::st_done;
                     end
                  end
               end
            end
         end
         fch_pkg::st_done: begin
            if (buf_ready) begin
               next_s.st = fch_pkg::st_idle;
            end
         end
         default: begin
            next_s.st = fch_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         s <= RST;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   sequence q_take(logic [7:0] op);
      accept && cmd_code == op;
   endsequence
   sequence q_loader_go;
      loader_enter && boot_vec_map ##1 !loader_enter && cmd_ready;
   endsequence

   a_ready_idle: assert property (accept && cmd_code !=
      fch_pkg::OP_LOADER |=> !cmd_ready) else $error("ready while working");
   a_unknown_code: assert property (accept && !(cmd_code >=
      fch_pkg::OP_ARM && cmd_code <= fch_pkg::OP_LOADER) |=>
      s.status == fch_pkg::status_unknown_op && !flash_start)
      else $error("unknown code not refused");
   a_dst_align: assert property (q_take(fch_pkg::OP_PROG) ##0 (!busy
      && cmd_param0[7:0] != 8'h00) |=>
      s.status == fch_pkg::status_dst_misaligned)
      else $error("misaligned destination accepted");
   a_src_align: assert property (q_take(fch_pkg::OP_PROG) ##0 (!busy
      && cmd_param0[7:0] == 8'h00 && cmd_param1[1:0] != 2'h0) |=>
      s.status == fch_pkg::status_src_misaligned)
      else $error("misaligned source accepted");
   a_bad_length: assert property (q_take(fch_pkg::OP_PROG) ##0 (!busy
      && cmd_param0[7:0] == 8'h00 && cmd_param1[1:0] == 2'h0
      && !len_ok) |=> s.status == fch_pkg::status_bad_length
      && !flash_start) else $error("bad length accepted");
   a_start_ok: assert property ($rose(flash_start) |->
      s.status == fch_pkg::status_ok
      && (s.armed & sec_mask(s.fl_a[SW-1:0], s.fl_b[SW-1:0])) == '0
      || !s.fl_erase) else $error("start without success or disarm");
   a_boot_unarmed: assert property (!s.armed[BOOT_SEC])
      else $error("boot sector armed");
   a_busy_erase: assert property (q_take(fch_pkg::OP_ERASE) ##0 busy
      |=> s.status == fch_pkg::status_busy && !flash_start)
      else $error("erase while busy");
   a_part_id: assert property (q_take(fch_pkg::OP_ID) |=>
      s.status == fch_pkg::status_ok && s.r0 == PART_ID ##1 res_valid
      || !buf_ready) else $error("identification answer wrong");
   a_version: assert property (q_take(fch_pkg::OP_VER) |=>
      s.r0[15:0] == {VER_MAJOR, VER_MINOR})
      else $error("version bytes wrong");
   a_loader_entry: assert property (q_take(fch_pkg::OP_LOADER) |=>
      q_loader_go) else $error("loader entry sequence wrong");
   a_loader_pins: assert property (boot_vec_map |->
      peripheral_bus_divider == 2'h0 && !loader_rx_pin_oe)
      else $error("loader pin or divider wrong");
   a_read_block: assert property (flash_hw_busy |->
      array_read_block && !(mem_rd_req && {1'b0, mem_rd_addr}
      < FLASH_BYTES)) else $error("flash read while busy");
endmodule

// File: verif/fch_mem_model.sv
`timescale 1ns/1ps
module fch_mem_model (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic reset_n,
   // Read port
   input wire logic mem_rd_req,
   input wire logic [31:0] mem_rd_addr,
   output logic mem_rd_ack,
   output logic [31:0] mem_rd_data,
   // Flash engine
   input wire logic flash_start,
   output logic flash_hw_busy
);
   logic [4:0] cnt;
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 5'h00;
         mem_rd_ack <= 1'b0;
      end else begin
         cnt <= flash_start ? 5'h14 : cnt - {4'h0, |cnt};
         mem_rd_ack <= mem_rd_req & !mem_rd_ack;
      end
   end
   assign flash_hw_busy = |cnt;
   // One used word in sector 1; junk on the bus outside an ack
   assign mem_rd_data = !mem_rd_ack ? ~mem_rd_addr :
      mem_rd_addr[30] ? mem_rd_addr :
      mem_rd_addr == 32'h0000_1010 ? 32'h0000_5A5A : 32'hFFFF_FFFF;
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   localparam logic [31:0] KHZ = 32'h0000_61A8;
   logic clk_sys, reset_n, cmd_valid, cmd_ready, res_valid, res_ready;
   logic [7:0] cmd_code;
   logic [31:0] cmd_param0, cmd_param1, cmd_param2, cmd_param3;
   logic [3:0] res_status;
   logic [31:0] res_word0, res_word1, mem_rd_addr, mem_rd_data;
   logic mem_rd_req, mem_rd_ack, flash_start, flash_hw_busy, flash_erase;
   logic [31:0] flash_a, flash_b, flash_len, core_clock_khz;
   logic array_read_block, loader_enter, boot_vec_map, app_rx_oe;
   logic loader_rx_pin_oe;
   logic [1:0] app_pbus_div, peripheral_bus_divider;
   int bad_count, checks;
   fch_core u_fch_core (.*);
   fch_mem_model u_fch_mem_model (.*);
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   task chk(input logic ok);
      checks++;
      if (!ok) begin
         bad_count++;
         $display("[FAIL] %0t result differs", $time);
      end
   endtask
   task automatic issue(input logic [7:0] c, input logic [31:0] a, b, n);
      int k;
      k = 0;
      while (cmd_ready !== 1'b1 && k < 99) begin
         @(negedge clk_sys);
         k++;
      end
      if (cmd_ready !== 1'b1) chk(1'b0);
      cmd_code = c;
      cmd_param0 = a;
      cmd_param1 = b;
      cmd_param2 = n;
      cmd_valid = 1'b1;
      @(negedge clk_sys);
      cmd_valid = 1'b0;
   endtask
   task automatic take(input logic [3:0] s, input logic [31:0] e0, e1);
      int k;
      k = 0;
      while (res_valid !== 1'b1 && k < 9999) begin
         @(negedge clk_sys);
         k++;
      end
      chk(res_valid === 1'b1 && res_status === s && res_word0 === e0
         && res_word1 === e1);
      res_ready = 1'b1;
      @(negedge clk_sys);
      res_ready = 1'b0;
      @(negedge clk_sys);
   endtask
   task run(input logic [7:0] c, input logic [31:0] a, b, n = 0,
         input logic [3:0] s = 0, input logic [31:0] e0 = 0);
      issue(c, a, b, n);
      take(s, e0, 32'h0);
   endtask
   task t_info;
      run(8'h36, 0, 0, 0, 4'h0, 32'h0000_1234);
      run(8'h37, 0, 0, 0, 4'h0, 32'h0000_3130);
      run(8'h3A, 0, 0, 0, 4'h1);
      run(8'h00, 0, 0, 0, 4'h1);
      $display("info done");
   endtask
   task t_prog;
      run(8'h33, 32'h1001, 32'h4000_0000, 32'h100, 4'h3);
      run(8'h33, 32'h1000, 32'h4000_0002, 32'h100, 4'h2);
      run(8'h33, 32'h1000, 32'h4000_0000, 32'h300, 4'h6);
      run(8'h33, 32'h1000, 32'h4000_7F00, 32'h200, 4'h4);
      run(8'h33, 32'hF000, 32'h4000_0000, 32'h100, 4'h9);
      run(8'h33, 32'h1000, 32'h4000_0000, 32'h100, 4'h9);
      run(8'h32, 32'h1, 32'h1);
      run(8'h33, 32'h1000, 32'h4000_0000, 32'h100);
      chk(flash_len === 32'h100 && core_clock_khz === KHZ);
      chk(flash_b === 32'h4000_0000 && flash_erase === 1'b0);
      run(8'h32, 32'h1, 32'h1, 0, 4'hB);
      chk(array_read_block === 1'b1);
      run(8'h38, 32'h2000, 32'h3000, 32'h4);
      repeat (24) @(negedge clk_sys);
      run(8'h33, 32'h1000, 32'h4000_0000, 32'h100, 4'h9);
      run(8'h32, 32'h1, 32'h1);
      run(8'h33, 32'h1100, 32'h4000_0100, 32'h100);
      repeat (24) @(negedge clk_sys);
      $display("program done");
   endtask
   task t_erase;
      run(8'h32, 32'hF, 32'hF, 0, 4'h7);
      run(8'h34, 32'h3, 32'h2, KHZ, 4'h7);
      run(8'h34, 32'h2, 32'h2, KHZ, 4'h9);
      run(8'h32, 32'h2, 32'h3);
      run(8'h34, 32'h2, 32'h3, KHZ);
      chk(flash_erase === 1'b1 && flash_a === 32'h2 && flash_b === 32'h3);
      run(8'h34, 32'h2, 32'h3, KHZ, 4'hB);
      repeat (24) @(negedge clk_sys);
      run(8'h34, 32'h2, 32'h3, KHZ, 4'h9);
      $display("erase done");
   endtask
   task t_read;
      issue(8'h35, 32'h1, 32'h1, 0);
      take(4'h8, 32'h10, 32'h5A5A);
      run(8'h35, 32'h2, 32'h2);
      run(8'h38, 32'h1000, 32'h2000, 32'h20, 4'hA, 32'h10);
      run(8'h38, 32'h2000, 32'h3000, 32'h8);
      run(8'h38, 32'h2000, 32'h3000, 32'h6, 4'h6);
      run(8'h38, 32'h2002, 32'h3000, 32'h8, 4'h3);
      run(8'h38, 32'h2000, 32'h5000_0000, 32'h8, 4'h4);
      $display("read done");
   endtask
   task t_buf;
      issue(8'h36, 0, 0, 0);
      issue(8'h37, 0, 0, 0);
      issue(8'h36, 0, 0, 0);
      repeat (4) @(negedge clk_sys);
      chk(cmd_ready === 1'b0 && res_valid === 1'b1);
      take(4'h0, 32'h0000_1234, 32'h0);
      take(4'h0, 32'h0000_3130, 32'h0);
      take(4'h0, 32'h0000_1234, 32'h0);
      $display("buffer done");
   endtask
   task t_load;
      chk(loader_rx_pin_oe === 1'b1 && peripheral_bus_divider === 2'h2);
      issue(8'h39, 0, 0, 0);
      chk(loader_enter === 1'b1 && cmd_ready === 1'b1);
      repeat (3) @(negedge clk_sys);
      chk(boot_vec_map === 1'b1 && res_valid === 1'b0);
      chk(loader_rx_pin_oe === 1'b0 && peripheral_bus_divider === 2'h0);
      reset_n = 1'b0;
      @(negedge clk_sys);
      chk(boot_vec_map === 1'b0 && peripheral_bus_divider === 2'h2);
      reset_n = 1'b1;
      $display("loader done");
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      #400_000;
      bad_count++;
      end_sim;
   end
   initial begin
      {reset_n, cmd_valid, res_ready, cmd_code} = 0;
      {cmd_param0, cmd_param1, cmd_param2} = 0;
      cmd_param3 = KHZ;
      app_rx_oe = 1'b1;
      app_pbus_div = 2'h2;
      repeat (16) @(negedge clk_sys);
      reset_n = 1'b1;
      t_info;
      t_prog;
      t_erase;
      t_read;
      t_buf;
      t_load;
      end_sim;
   end
endmodule
